// File: rtl/txy_timer_ctrl.sv
// control and status logic for timer channels y and x
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module txy_timer_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // counter and constant values of both channels, external reset
  input wire txy_pkg::txy_chan_t channel_y,
  input wire txy_pkg::txy_chan_t channel_x,
  input wire logic ext_reset,
  // pins and requests
  output logic channel_y_output_pin,
  output logic channel_x_output_pin,
  output logic capture_interrupt_request,
  output logic irq
);

  txy_pkg::txy_chan_t chan [2];
  txy_pkg::txy_csr_t csr_r [2];
  logic [7:0] armed_r [2];
  logic [7:0] prev_cnt_r [2];
  logic [1:0] pin_r;
  logic [1:0] match_a;
  logic [1:0] match_b;
  logic [1:0] wrap;
  logic cap_evt;
  logic ext_prev_r;
  txy_pkg::txy_cap_st_t cap_st_r;
  logic [6:0] irq_st_r;
  logic [6:0] irq_mask_r;
  logic [6:0] irq_set;
  logic [7:0] rdata_r;
  logic rd_st;

  assign chan[0] = channel_y;
  assign chan[1] = channel_x;

  // next pin level for one match and its select code
  function automatic logic pin_apply(logic cur, logic hit, logic [1:0] sel);
    logic res;
    res = cur;
    if (hit) begin
      case (txy_pkg::txy_os_t'(sel))
        txy_pkg::TXY_OS_LOW: res = 1'b0;
        txy_pkg::TXY_OS_HIGH: res = 1'b1;
        txy_pkg::TXY_OS_TOGGLE: res = ~cur;
        default: res = cur;
      endcase
    end
    return res;
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      localparam logic [7:0] FMASK = (ch == 0) ? txy_pkg::TXY_FLAGS_Y :
                                                txy_pkg::TXY_FLAGS_X;
      localparam logic [3:0] MY_ADDR = (ch == 0) ?
        txy_pkg::TXY_ADDR_CSR_Y : txy_pkg::TXY_ADDR_CSR_X;
      logic upd;
      logic wr_hit;
      logic rd_hit;
      logic cap_set;
      logic [7:0] setv;
      logic [7:0] clr;
      logic [7:0] cur;

      // a match counts once per counter step, so a stopped counter
      // sitting on the constant does not toggle the pin every cycle
      assign upd = chan[ch].counter != prev_cnt_r[ch];
      assign match_b[ch] = upd &&
        (chan[ch].counter == chan[ch].constant_b);
      assign match_a[ch] = upd &&
        (chan[ch].counter == chan[ch].constant_a);
      assign wrap[ch] = (prev_cnt_r[ch] == txy_pkg::TXY_CNT_MAX) &&
        (chan[ch].counter == txy_pkg::TXY_CNT_MIN);
      assign cap_set = (ch == 1) ? cap_evt : 1'b0;
      assign wr_hit = reg_wr && (reg_addr == MY_ADDR);
      assign rd_hit = reg_rd && (reg_addr == MY_ADDR);
      assign setv = {match_b[ch], match_a[ch], wrap[ch], cap_set, 4'h0};
      assign cur = csr_r[ch];
      // only zeros written to flags armed by an earlier read clear them
      assign clr = {8{wr_hit}} & armed_r[ch] & ~reg_wdata & FMASK;

      // counter history for match and wrap detection
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_cnt_r[ch] <= txy_pkg::TXY_CNT_MIN;
        end else begin
          prev_cnt_r[ch] <= chan[ch].counter;
        end
      end

      // a read arms the flags it saw at one; a write to this register disarms
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          armed_r[ch] <= 8'h00;
        end else if (rd_hit) begin
          armed_r[ch] <= cur & FMASK;
        end else if (wr_hit) begin
          armed_r[ch] <= 8'h00;
        end
      end

      // flags: set wins over clear; other bits plain read/write
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          csr_r[ch] <= txy_pkg::TXY_CSR_RST;
        end else begin
          csr_r[ch] <= ((setv | (cur & ~clr)) & FMASK) |
            ((wr_hit ? reg_wdata : cur) & ~FMASK);
        end
      end

      // output pin: compare a applied first, then compare b on top
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_r[ch] <= 1'b0;
        end else begin
          pin_r[ch] <= pin_apply(pin_apply(pin_r[ch], match_a[ch],
            csr_r[ch].os_a), match_b[ch], csr_r[ch].os_b);
        end
      end
    end
  endgenerate

  // capture: rising edge arms, following falling edge fires
  assign cap_evt = (cap_st_r == txy_pkg::TXY_CAP_WAIT_FALL) &&
    ext_prev_r && !ext_reset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_reset;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_st_r <= txy_pkg::TXY_CAP_WAIT_RISE;
    end else begin
      case (cap_st_r)
        txy_pkg::TXY_CAP_WAIT_RISE: begin
          if (!ext_prev_r && ext_reset) begin
            cap_st_r <= txy_pkg::TXY_CAP_WAIT_FALL;
          end
        end
        txy_pkg::TXY_CAP_WAIT_FALL: begin
          if (ext_prev_r && !ext_reset) begin
            cap_st_r <= txy_pkg::TXY_CAP_WAIT_RISE;
          end
        end
        default: cap_st_r <= txy_pkg::TXY_CAP_WAIT_RISE;
      endcase
    end
  end

  // capture request gated by channel y enable bit
  assign capture_interrupt_request =
    csr_r[1].bit4 && csr_r[0].bit4;

  // event summary into the sticky interrupt status
  always_comb begin
    irq_set = 7'h00;
    irq_set[txy_pkg::TXY_IRQ_COMPARE_A_FLAG_Y] = match_a[0];
    irq_set[txy_pkg::TXY_IRQ_COMPARE_B_FLAG_Y] = match_b[0];
    irq_set[txy_pkg::TXY_IRQ_OVF_Y] = wrap[0];
    irq_set[txy_pkg::TXY_IRQ_COMPARE_A_FLAG_X] = match_a[1];
    irq_set[txy_pkg::TXY_IRQ_COMPARE_B_FLAG_X] = match_b[1];
    irq_set[txy_pkg::TXY_IRQ_OVF_X] = wrap[1];
    irq_set[txy_pkg::TXY_IRQ_CAP] = cap_evt;
  end

  assign rd_st = reg_rd && (reg_addr == txy_pkg::TXY_ADDR_IRQ_ST);

  // a read clears what it returned; a new event in that cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_r <= txy_pkg::TXY_IRQ_RST;
    end else begin
      irq_st_r <= irq_set | (rd_st ? 7'h00 : irq_st_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= txy_pkg::TXY_IRQ_RST;
    end else if (reg_wr && (reg_addr == txy_pkg::TXY_ADDR_IRQ_MASK)) begin
      irq_mask_r <= reg_wdata[6:0];
    end
  end

  assign irq = |(irq_st_r & irq_mask_r);

  // read data stand in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        txy_pkg::TXY_ADDR_CSR_Y: rdata_r <= csr_r[0];
        txy_pkg::TXY_ADDR_CSR_X: rdata_r <= csr_r[1];
        txy_pkg::TXY_ADDR_IRQ_ST: rdata_r <= {1'b0, irq_st_r};
        txy_pkg::TXY_ADDR_IRQ_MASK: rdata_r <= {1'b0, irq_mask_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign channel_y_output_pin = pin_r[0];
  assign channel_x_output_pin = pin_r[1];

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  y_cmpb_set_a: assert property (match_b[0] |=> csr_r[0].compare_b_flag)
    else $error("y compare b flag not set");
  y_cmpa_set_a: assert property (match_a[0] |=> csr_r[0].compare_a_flag)
    else $error("y compare a flag not set");
  y_ovf_set_a: assert property (wrap[0] |=> csr_r[0].overflow_flag)
    else $error("y overflow flag not set");
  flag_one_keep_a: assert property (reg_wr &&
    reg_addr == txy_pkg::TXY_ADDR_CSR_Y && reg_wdata[7] &&
    csr_r[0].compare_b_flag |=> csr_r[0].compare_b_flag)
    else $error("writing one changed a flag");
  clr_after_read_a: assert property ($fell(csr_r[0].compare_a_flag) |->
    $past(reg_wr) && $past(armed_r[0][6]))
    else $error("flag cleared without read then write");
  cap_req_gate_a: assert property (capture_interrupt_request |->
    csr_r[0].bit4 && csr_r[1].bit4)
    else $error("capture request while disabled");
  y_pin_low_a: assert property (match_b[0] && !match_a[0] &&
    csr_r[0].os_b == txy_pkg::TXY_OS_LOW |=> !channel_y_output_pin)
    else $error("y pin not driven low");
  y_pin_tgl_a: assert property (match_a[0] && !match_b[0] &&
    csr_r[0].os_a == txy_pkg::TXY_OS_TOGGLE |=>
    channel_y_output_pin != $past(channel_y_output_pin))
    else $error("y pin not toggled");
  x_cmp_set_a: assert property (match_b[1] && match_a[1] |=>
    csr_r[1].compare_b_flag && csr_r[1].compare_a_flag)
    else $error("x compare flags not set");
  x_ovf_set_a: assert property (wrap[1] |=> csr_r[1].overflow_flag)
    else $error("x overflow flag not set");
  cap_seq_flag_a: assert property (!ext_reset ##1 ext_reset [*2]
    ##1 !ext_reset |=> csr_r[1].bit4)
    else $error("capture flag not set");
  cap_clr_a: assert property ($fell(csr_r[1].bit4) |->
    $past(reg_wr) && !$past(reg_wdata[4]) && $past(armed_r[1][4]))
    else $error("capture flag cleared wrongly");
  x_pin_high_a: assert property (match_b[1] &&
    csr_r[1].os_b == txy_pkg::TXY_OS_HIGH |=> channel_x_output_pin)
    else $error("x pin not driven high");
  x_pin_a_high_a: assert property (match_a[1] && !match_b[1] &&
    csr_r[1].os_a == txy_pkg::TXY_OS_HIGH |=> channel_x_output_pin)
    else $error("x pin not driven high on a");

  cover_flag_clear: cover property (reg_rd &&
    reg_addr == txy_pkg::TXY_ADDR_CSR_Y ##1 reg_wr ##1
    !csr_r[0].compare_a_flag);
  cover_capture: cover property (cap_evt ##1 capture_interrupt_request);
  cover_toggle: cover property ($changed(channel_x_output_pin));
  cover_irq: cover property (irq ##[1:4] rd_st);
endmodule

// File: rtl/txy_pkg.sv
// constants and types for the timer x/y control and status block
//
// Overview of operation
// - set channel y compare b flag, bit 7, on counter equal constant b
// - set channel y compare a flag, bit 6, on counter equal constant a
// - set channel y overflow flag, bit 5, on counter wrap ff to 00
// - flags accept only written zeros, for clearing; writing one keeps them
// - y flags clear only after a read seeing one then a zero write
// - y bit 4 enables capture interrupt request while x capture flag set
// - y compare b match drives y pin per bits 3:2: keep, low, high, toggle
// - y compare a match drives y pin per bits 1:0, same four codes
// - set channel x compare b flag, bit 7, on counter equal constant b
// - set channel x compare a flag, bit 6, on counter equal constant a
// - set channel x overflow flag, bit 5, on counter wrap ff to 00
// - set x capture flag, bit 4, on rising then falling external reset
// - x capture flag clears on zero write after a read seeing one
// - x compare b match drives x pin per bits 3:2: keep, low, high, toggle
// - x compare a match drives x pin per bits 1:0, same four codes
// - every bit of both control/status registers is zero after reset
package txy_pkg;
  // register map, word index on the plain register port
  localparam logic [3:0] TXY_ADDR_CSR_Y = 4'h0;
  localparam logic [3:0] TXY_ADDR_CSR_X = 4'h1;
  localparam logic [3:0] TXY_ADDR_IRQ_ST = 4'h2;
  localparam logic [3:0] TXY_ADDR_IRQ_MASK = 4'h3;
  // control/status reset value and flag bit masks
  localparam logic [7:0] TXY_CSR_RST = 8'h00;
  localparam logic [7:0] TXY_FLAGS_Y = 8'he0;
  localparam logic [7:0] TXY_FLAGS_X = 8'hf0;
  // counter wrap points
  localparam logic [7:0] TXY_CNT_MAX = 8'hff;
  localparam logic [7:0] TXY_CNT_MIN = 8'h00;
  // interrupt status layout
  localparam int TXY_IRQ_W = 7;
  localparam logic [6:0] TXY_IRQ_RST = 7'h00;
  localparam int TXY_IRQ_COMPARE_A_FLAG_Y = 0;
  localparam int TXY_IRQ_COMPARE_B_FLAG_Y = 1;
  localparam int TXY_IRQ_OVF_Y = 2;
  localparam int TXY_IRQ_COMPARE_A_FLAG_X = 3;
  localparam int TXY_IRQ_COMPARE_B_FLAG_X = 4;
  localparam int TXY_IRQ_OVF_X = 5;
  localparam int TXY_IRQ_CAP = 6;

  // output select codes
  typedef enum logic [1:0] {
    TXY_OS_KEEP = 2'b00,
    TXY_OS_LOW = 2'b01,
    TXY_OS_HIGH = 2'b10,
    TXY_OS_TOGGLE = 2'b11
  } txy_os_t;

  // capture edge sequence states
  typedef enum logic {
    TXY_CAP_WAIT_RISE = 1'b0,
    TXY_CAP_WAIT_FALL = 1'b1
  } txy_cap_st_t;

  // control/status register layout; bit4 is enable on y, flag on x
  typedef struct packed {
    logic compare_b_flag;
    logic compare_a_flag;
    logic overflow_flag;
    logic bit4;
    logic [1:0] os_b;
    logic [1:0] os_a;
  } txy_csr_t;

  // counter and constants of one channel
  typedef struct packed {
    logic [7:0] counter;
    logic [7:0] constant_a;
    logic [7:0] constant_b;
  } txy_chan_t;
endpackage

// File: verification/txy_timer_ctrl_test.sv
// self-checking bench for the timer x/y control and status block
`timescale 1ns/10ps
module txy_timer_ctrl_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  txy_pkg::txy_chan_t channel_y = '0;
  txy_pkg::txy_chan_t channel_x = '0;
  logic ext_reset = 1'b0;
  logic channel_y_output_pin, channel_x_output_pin;
  logic capture_interrupt_request, irq;
  // behavioural model state
  logic [7:0] my, mx, py, px, mrd, ary, arx, cb;
  logic [6:0] mst, mmsk;
  logic [2:0] ey, ex;
  logic mpy, mpx, mcs, pe, ec, wy, wx, t;
  int cyc = 0;
  int checks = 0;
  int n_mismatch = 0;
  int i;

  always #10 clk = ~clk;

  txy_timer_ctrl DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .channel_y(channel_y), .channel_x(channel_x),
    .ext_reset(ext_reset), .channel_y_output_pin(channel_y_output_pin),
    .channel_x_output_pin(channel_x_output_pin),
    .capture_interrupt_request(capture_interrupt_request), .irq(irq));

  // events {overflow, compare b, compare a}; a match needs a counter step
  function automatic logic [2:0] ev(input txy_pkg::txy_chan_t c,
                                    input logic [7:0] p);
    ev = {p == 8'hff && c.counter == 8'h00,
          c.counter != p && c.counter == c.constant_b,
          c.counter != p && c.counter == c.constant_a};
  endfunction

  function automatic logic pin(input logic p, input logic [1:0] os);
    case (os)
      2'b01: pin = 1'b0;
      2'b10: pin = 1'b1;
      2'b11: pin = ~p;
      default: pin = p;
    endcase
  endfunction

  // model: everything is computed from the values before this edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {my, mx, py, px, mrd, ary, arx} = '0;
      {mst, mmsk} = '0;
      {mpy, mpx, mcs, pe} = '0;
    end else begin
      ey = ev(channel_y, py);
      ex = ev(channel_x, px);
      ec = mcs & ~ext_reset;
      mrd = !reg_rd ? 8'h00 : reg_addr == 4'h0 ? my : reg_addr == 4'h1 ? mx :
        reg_addr == 4'h2 ? {1'b0, mst} :
        reg_addr == 4'h3 ? {1'b0, mmsk} : 8'h00;
      wy = reg_wr && reg_addr == 4'h0;
      wx = reg_wr && reg_addr == 4'h1;
      // a then b, b acting on the result of a
      t = ey[0] ? pin(mpy, my[1:0]) : mpy;
      mpy = ey[1] ? pin(t, my[3:2]) : t;
      t = ex[0] ? pin(mpx, mx[1:0]) : mpx;
      mpx = ex[1] ? pin(t, mx[3:2]) : t;
      // set beats a same-cycle clear so no event is lost
      my = (my & 8'he0 & ~(wy ? ary & ~reg_wdata : 8'h00)) |
        {ey[1], ey[0], ey[2], 5'h00} |
        (wy ? reg_wdata & 8'h1f : my & 8'h1f);
      mx = (mx & 8'hf0 & ~(wx ? arx & ~reg_wdata : 8'h00)) |
        {ex[1], ex[0], ex[2], ec, 4'h0} |
        (wx ? reg_wdata & 8'h0f : mx & 8'h0f);
      ary = (reg_rd && reg_addr == 4'h0) ? mrd & 8'he0 : wy ? 8'h00 : ary;
      arx = (reg_rd && reg_addr == 4'h1) ? mrd & 8'hf0 : wx ? 8'h00 : arx;
      mst = ((reg_rd && reg_addr == 4'h2) ? 7'h00 : mst) | {ec, ex, ey};
      if (reg_wr && reg_addr == 4'h3) mmsk = reg_wdata[6:0];
      mcs = mcs ? ext_reset : ext_reset & ~pe;
      pe = ext_reset;
      py = channel_y.counter;
      px = channel_x.counter;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // outputs compared with the model in the middle of every cycle
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      check(reg_rdata, mrd);
      check({7'h00, channel_y_output_pin}, {7'h00, mpy});
      check({7'h00, channel_x_output_pin}, {7'h00, mpx});
      check({7'h00, capture_interrupt_request}, {7'h00, mx[4] & my[4]});
      check({7'h00, irq}, {7'h00, |(mst & mmsk)});
    end
  end

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well above the roughly 700 cycles the tests take
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  // one bus cycle; strobes drop only when the next call asks so
  task automatic drive(input logic w, input logic r, input logic [3:0] a,
                       input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  function automatic logic [7:0] rc();
    case ($urandom % 5)
      0: rc = 8'hff;
      1: rc = 8'h00;
      2: rc = 8'h10;
      3: rc = 8'h20;
      default: rc = 8'($urandom);
    endcase
  endfunction

  initial begin
    i = $urandom(32'h81767ea2);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i++) drive(1'b0, 1'b1, 4'(i), 8'h00);
    $display("test reset values done");
    // every output code for a and b, and a and b on one value
    for (i = 0; i < 16; i++) begin
      cb = i[0] ? 8'h10 : 8'h20;
      channel_y <= {8'h0f, 8'h10, cb};
      channel_x <= {8'h0f, 8'h10, cb};
      drive(1'b1, 1'b0, 4'h0, {4'h0, 4'(i)});
      drive(1'b1, 1'b0, 4'h1, {4'h0, 4'(i)});
      channel_y.counter <= 8'h10;
      channel_x.counter <= 8'h10;
      drive(1'b0, 1'b0, 4'h0, 8'h00);
      channel_y.counter <= 8'h20;
      channel_x.counter <= 8'h20;
      drive(1'b0, 1'b0, 4'h0, 8'h00);
    end
    $display("test output codes done");
    // wrap, then clear sequences, the y one with a set landing on its clearing write
    channel_y.counter <= 8'hff;
    channel_x.counter <= 8'hff;
    drive(1'b1, 1'b0, 4'h3, 8'h7f);
    channel_y.counter <= 8'h00;
    channel_x.counter <= 8'h00;
    drive(1'b0, 1'b0, 4'h0, 8'h00);
    ext_reset <= 1'b1;
    drive(1'b0, 1'b1, 4'h2, 8'h00);
    ext_reset <= 1'b0;
    drive(1'b0, 1'b0, 4'h0, 8'h00);
    drive(1'b1, 1'b0, 4'h0, 8'h10);
    for (i = 0; i < 2; i++) begin
      drive(1'b1, 1'b0, 4'(i), 8'h00);
      drive(1'b0, 1'b1, 4'(i), 8'h00);
      drive(1'b1, 1'b0, 4'(i), 8'hff);
      drive(1'b0, 1'b1, 4'(i), 8'h00);
      channel_y.counter <= 8'h10;
      channel_x.counter <= 8'h10;
      drive(1'b1, 1'b0, 4'(i), 8'h00);
      drive(1'b0, 1'b1, 4'(i), 8'h00);
      drive(1'b1, 1'b0, 4'(i), 8'h00);
      drive(1'b0, 1'b1, 4'(i), 8'h00);
    end
    drive(1'b1, 1'b0, 4'h2, 8'h00);
    drive(1'b1, 1'b0, 4'h9, 8'hff);
    drive(1'b0, 1'b1, 4'h9, 8'h00);
    drive(1'b0, 1'b1, 4'h2, 8'h00);
    drive(1'b1, 1'b0, 4'h3, 8'h00);
    $display("test clear and interrupt done");
    // random traffic on every input
    for (i = 0; i < 600; i++) begin
      t = 1'($urandom);
      channel_y <= {rc(), rc(), rc()};
      channel_x <= {rc(), rc(), rc()};
      ext_reset <= 1'($urandom);
      drive(t, ~t & 1'($urandom), 4'($urandom % 4), 8'($urandom));
    end
    $display("test random traffic done");
    // second reset in mid-run
    rst_n <= 1'b0;
    channel_y <= '0;
    channel_x <= '0;
    ext_reset <= 1'b0;
    drive(1'b0, 1'b0, 4'h0, 8'h00);
    rst_n <= 1'b1;
    drive(1'b0, 1'b0, 4'h0, 8'h00);
    for (i = 0; i < 4; i++) drive(1'b0, 1'b1, 4'(i), 8'h00);
    drive(1'b0, 1'b0, 4'h0, 8'h00);
    $display("test second reset done");
    final_report();
  end
endmodule
